// [bench/sre_bus_master.sv]
// Far-side bus master model: makes the serial clock, drives and samples data.
// Assumes the bench resolves the pulled-up data wire and feeds it back.
`default_nettype none
// ==========================================
// Bus master model
module sre_bus_master (
    input wire logic clk,
    input wire logic sda_line,
    output var logic scl_o,
    output var logic sda_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus: clock stands high between frames, data left to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        scl_o <= 1'b0;
        tick(2);
        sda_o <= b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        s = sda_line;
        tick(2);
    endtask
    task automatic start();
        sda_o <= 1'b0;
        tick(4);
    endtask
    task automatic rstart();
        scl_o <= 1'b0;
        tick(2);
        sda_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
    endtask
    task automatic stop();
        scl_o <= 1'b0;
        tick(2);
        sda_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    endtask
endmodule // sre_bus_master
`default_nettype wire

// [bench/sre_read_engine_bench.sv]
// Self-checking bench for the serial read engine.
// Assumes the bus master model on the far side and the bound port checker.
`default_nettype none
// ==========================================
// Bench top
module sre_read_engine_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic sys_rst;
    logic load_valid;
    logic [7:0] load_addr;
    logic [7:0] load_data;
    logic [2:0] strap;
    logic [7:0] ref_mem [256];
    wire scl_in;
    wire sda_m;
    wire sda_in;
    wire sda_out;
    wire sda_oe;
    wire load_ready;
    wire sess_busy;
    wire [7:0] cur_addr;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    // Pulled-up wire: low when either party pulls
    assign sda_in = sda_m & ~sda_oe;
    sre_read_engine uut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_in(strap), .load_valid(load_valid), .load_ready(load_ready),
        .load_addr(load_addr), .load_data(load_data), .sess_busy(sess_busy), .cur_addr(cur_addr));
    sre_bus_master mst (.clk(clk), .sda_line(sda_in), .scl_o(scl_in), .sda_o(sda_m));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Valid stays up between words so it is never written twice in a step
    task automatic push(input logic [7:0] a, input logic [7:0] d);
        load_valid <= 1'b1;
        load_addr <= a;
        load_data <= d;
        ref_mem[a] = d;
        @(posedge clk);
        while (load_ready !== 1'b1) @(posedge clk);
    endtask
    task automatic rd_bytes(input logic [7:0] a, input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            mst.recv(i < n - 1, d);
            chk("data", ref_mem[8'(a + i)], d);
        end
        mst.stop();
        repeat (6) @(posedge clk);
        chk("busy", 8'h00, {7'h0, sess_busy});
        chk("addr", 8'(a + n), cur_addr);
        $display("test read at %h done", a);
    endtask
    task automatic t_sel(input logic [7:0] a, input int n);
        logic ack;
        mst.start();
        mst.send({4'ha, strap, 1'b0}, ack);
        chk("ack_w", 8'h01, {7'h0, ack});
        mst.send(a, ack);
        chk("ack_a", 8'h01, {7'h0, ack});
        mst.rstart();
        mst.send({4'ha, strap, 1'b1}, ack);
        chk("ack_r", 8'h01, {7'h0, ack});
        rd_bytes(a, n);
    endtask
    task automatic t_cur(input logic [7:0] a);
        logic ack;
        mst.start();
        mst.send({4'ha, strap, 1'b1}, ack);
        chk("ack_c", 8'h01, {7'h0, ack});
        rd_bytes(a, 2);
    endtask
    task automatic t_bad(input logic [7:0] sel);
        logic ack;
        mst.start();
        mst.send(sel, ack);
        chk("nak", 8'h00, {7'h0, ack});
        mst.stop();
        chk("idle", 8'h00, {7'h0, sess_busy});
        $display("test bad select done");
    endtask
    // Session held open after the address byte so the buffer cannot drain
    task automatic t_fifo();
        logic ack;
        mst.start();
        mst.send({4'ha, strap, 1'b0}, ack);
        mst.send(8'h40, ack);
        chk("ack_f", 8'h01, {7'h0, ack});
        chk("held", 8'h01, {7'h0, sess_busy});
        for (int i = 0; i < 16; i++) begin
            push(8'(8'h40 + i), 8'(8'hc0 - i));
        end
        @(posedge clk);
        chk("full", 8'h00, {7'h0, load_ready});
        load_valid <= 1'b0;
        mst.stop();
        repeat (20) @(posedge clk);
        chk("drain", 8'h01, {7'h0, load_ready});
        $display("test fifo done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        load_valid = 1'b0;
        load_addr = 8'h00;
        load_data = 8'h00;
        strap = 3'h5;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rst_addr", 8'h00, cur_addr);
        for (int a = 0; a < 256; a++) begin
            push(8'(a), 8'(a * 7 + 3));
        end
        load_valid <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test load done");
        t_sel(8'h0e, 4);
        t_sel(8'hfe, 4);
        t_cur(8'h02);
        t_sel(8'h80, 1);
        t_bad({4'hb, strap, 1'b1});
        t_bad({4'ha, ~strap, 1'b1});
        t_fifo();
        t_sel(8'h3e, 4);
        t_cur(8'h42);
        wrap_up();
    end
endmodule // sre_read_engine_bench
`default_nettype wire

// [bench/sre_read_engine_monitor.sv]
// Port checker for the serial read engine.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
// ==========================================
// Port checker
module sre_read_monitor #(
    parameter ADDR_W = 8,
    parameter MEM_AW = 8,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire [2:0] strap_in,
    input wire load_valid,
    input wire load_ready,
    input wire [MEM_AW-1:0] load_addr,
    input wire [7:0] load_data,
    input wire sess_busy,
    input wire [ADDR_W-1:0] cur_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    a_drive_open: assert property (disable iff (sys_rst) sda_out == 1'b0)
        else $error("data pin drive value not low");
    a_edge_change: assert property (disable iff (sys_rst) $changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while serial clock high");
    a_level_hold: assert property (disable iff (sys_rst) $changed(sda_oe) |=> $stable(sda_oe) [*4])
        else $error("data drive level did not stand");
    a_reset_state: assert property (sys_rst |=> !sda_oe && !sess_busy && cur_addr == {ADDR_W{1'b0}} && load_ready)
        else $error("reset state wrong");
    a_stop_idle: assert property (disable iff (sys_rst)
        scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !sess_busy)
        else $error("no return to idle after stop");
    a_addr_quiet: assert property (disable iff (sys_rst)
        !sess_busy && !$past(sess_busy) |-> $stable(cur_addr))
        else $error("address counter moved while idle");
    a_drain_idle: assert property (disable iff (sys_rst) !load_ready && !sess_busy |=> load_ready)
        else $error("load buffer not drained while idle");
    a_busy_hold: assert property (disable iff (sys_rst) $past(sess_busy) |-> !$rose(load_ready))
        else $error("load buffer drained during a session");
endmodule // sre_read_monitor

bind sre_read_engine sre_read_monitor #(.ADDR_W(ADDR_W), .MEM_AW(MEM_AW), .FIFO_DEPTH(FIFO_DEPTH),
    .FIFO_AW(FIFO_AW)) mon (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_in(strap_in), .load_valid(load_valid),
    .load_ready(load_ready), .load_addr(load_addr), .load_data(load_data), .sess_busy(sess_busy),
    .cur_addr(cur_addr));
`default_nettype wire

// [core/sre_defs.vh]
// Constants used by the serial read engine; its load buffer uses none of them.
// Assumes inclusion by bare name from files under core/.
`ifndef SRE_DEFS_VH
`define SRE_DEFS_VH

// Fixed upper nibble of the device select byte
`define SRE_SEL_FIXED 4'ha
// Field positions inside a received select byte
`define SRE_SEL_HI 7
`define SRE_SEL_LO 4
`define SRE_STRAP_HI 3
`define SRE_STRAP_LO 1
`define SRE_RW_BIT 0
// Direction bit value that asks for a read
`define SRE_RW_READ 1'b1
// Bit counter values
`define SRE_BIT_FIRST 3'h0
`define SRE_BIT_LAST 3'h7
`define SRE_BIT_STEP 3'h1
// Address counter step, one bit wide so the sum keeps the counter's width
`define SRE_ADDR_STEP 1'b1
// Idle level of both bus lines
`define SRE_LINE_IDLE 1'b1
// Level driven on the data line when the pin is enabled
`define SRE_LINE_LOW 1'b0

`endif

// [core/sre_fifo.v]
// Word FIFO with valid/ready on both sides, used on the memory load path.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module sre_fifo #(
    parameter W = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] cnt_ff;
    wire do_wr;
    wire do_rd;

    // Full and empty come straight from the fill count
    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rd_ptr_ff];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // ============================================================
    // Storage and pointers
    always @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
        if (sys_rst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (do_rd & ~do_wr) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // sre_fifo

`default_nettype wire

// [core/sre_read_engine.v]
// Read side of a two-wire serial memory slave, with its byte array.
// Assumes a fast system clock that oversamples the serial clock and data pins.
`default_nettype none
`include "sre_defs.vh"

module sre_read_engine #(
    parameter ADDR_W = 8,
    parameter MEM_AW = 8,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [2:0] strap_in,
    input wire load_valid,
    output wire load_ready,
    input wire [MEM_AW-1:0] load_addr,
    input wire [7:0] load_data,
    output wire sess_busy,
    output wire [ADDR_W-1:0] cur_addr
);
    // ============================================================
    // State codes
    localparam S_IDLE = 3'b000;
    localparam S_SEL = 3'b001;
    localparam S_ACKW = 3'b010;
    localparam S_ACKD = 3'b011;
    localparam S_RXADR = 3'b100;
    localparam S_TX = 3'b101;
    localparam S_RACK = 3'b110;
    localparam S_WAIT = 3'b111;

    // Continuation chosen as a byte completes, acted on at the fall that ends its ack
    localparam N_RD = 2'b00;
    localparam N_ADR = 2'b01;
    localparam N_WAIT = 2'b10;
    localparam N_NEXT = 2'b11;

    reg [7:0] mem_ff [0:(1<<MEM_AW)-1];
    reg scl_s1_ff;
    reg scl_s2_ff;
    reg scl_s3_ff;
    reg sda_s1_ff;
    reg sda_s2_ff;
    reg sda_s3_ff;
    reg [2:0] strap_s1_ff;
    reg [2:0] strap_s2_ff;
    reg [2:0] st_ff;
    reg [2:0] nxt_st;
    reg [1:0] cont_ff;
    reg [1:0] nxt_cont;
    reg [2:0] cnt_ff;
    reg [2:0] nxt_cnt;
    reg [7:0] sh_ff;
    reg [7:0] nxt_sh;
    reg [ADDR_W-1:0] addr_ff;
    reg [ADDR_W-1:0] nxt_addr;
    reg oe_ff;
    reg nxt_oe;
    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;
    wire [7:0] rx_byte;
    wire sel_ok;
    wire [7:0] rd_byte;
    wire [MEM_AW+7:0] fifo_data;
    wire drain_valid;
    wire drain_ready;
    wire [MEM_AW+7:0] drain_data;

    // ============================================================
    // Pin synchronisers
    // Two flops before any logic; the third stage only serves edge finding
    always @(posedge clk) begin
        if (sys_rst) begin
            scl_s1_ff <= `SRE_LINE_IDLE;
            scl_s2_ff <= `SRE_LINE_IDLE;
            scl_s3_ff <= `SRE_LINE_IDLE;
            sda_s1_ff <= `SRE_LINE_IDLE;
            sda_s2_ff <= `SRE_LINE_IDLE;
            sda_s3_ff <= `SRE_LINE_IDLE;
            strap_s1_ff <= 3'h0;
            strap_s2_ff <= 3'h0;
        end else begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            strap_s1_ff <= strap_in;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // Serial clock edges and bus conditions
    // Both lines pass the same delay, so data stays aligned to the clock edges
    assign scl_rise = scl_s2_ff & ~scl_s3_ff;
    assign scl_fall = ~scl_s2_ff & scl_s3_ff;
    assign bus_start = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
    assign bus_stop = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

    // Byte completed by the bit sampled on this rising edge
    assign rx_byte = {sh_ff[6:0], sda_s2_ff};

    assign sel_ok = (rx_byte[`SRE_SEL_HI:`SRE_SEL_LO] == `SRE_SEL_FIXED) &&
                    (rx_byte[`SRE_STRAP_HI:`SRE_STRAP_LO] == strap_s2_ff);

    // array index uses low bits only
    // A counter wider than the array aliases instead of rolling at the array end
    assign rd_byte = mem_ff[addr_ff[MEM_AW-1:0]];

    // ============================================================
    // Bus sequencer
    always @* begin
        nxt_st = st_ff;
        nxt_cont = cont_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_addr = addr_ff;
        nxt_oe = oe_ff;
        if (bus_stop) begin
            nxt_st = S_IDLE;
            nxt_oe = 1'b0;
        end else if (bus_start) begin
            nxt_st = S_SEL;
            nxt_cnt = `SRE_BIT_FIRST;
            nxt_oe = 1'b0;
        end else begin
            case (st_ff)
                S_SEL: begin
                    if (scl_rise) begin
                        nxt_sh = rx_byte;
                        nxt_cnt = cnt_ff + `SRE_BIT_STEP;
                        if (cnt_ff == `SRE_BIT_LAST) begin
                            if (!sel_ok) begin
                                nxt_st = S_IDLE;
                            end else if (rx_byte[`SRE_RW_BIT] == `SRE_RW_READ) begin
                                nxt_st = S_ACKW;
                                nxt_cont = N_RD;
                            end else begin
                                nxt_st = S_ACKW;
                                nxt_cont = N_ADR;
                            end
                        end
                    end
                end
                S_RXADR: begin
                    if (scl_rise) begin
                        nxt_sh = rx_byte;
                        nxt_cnt = cnt_ff + `SRE_BIT_STEP;
                        if (cnt_ff == `SRE_BIT_LAST) begin
                            nxt_addr = {{(ADDR_W-1){1'b0}}, 1'b0} | rx_byte[ADDR_W-1:0];
                            nxt_st = S_ACKW;
                            nxt_cont = N_WAIT;
                        end
                    end
                end
                S_ACKW: begin
                    // Pull the line low from the fall before the ninth clock
                    if (scl_fall) begin
                        nxt_oe = 1'b1;
                        nxt_st = S_ACKD;
                    end
                end
                S_ACKD: begin
                    if (scl_fall) begin
                        nxt_cnt = `SRE_BIT_FIRST;
                        if (cont_ff == N_RD) begin
                            nxt_sh = rd_byte;
                            nxt_oe = ~rd_byte[7];
                            nxt_st = S_TX;
                        end else if (cont_ff == N_ADR) begin
                            nxt_oe = 1'b0;
                            nxt_st = S_RXADR;
                        end else begin
                            // Data bytes of a real write are not handled here
                            nxt_oe = 1'b0;
                            nxt_st = S_WAIT;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == `SRE_BIT_LAST) begin
                            nxt_oe = 1'b0;
                            nxt_st = S_RACK;
                            nxt_addr = addr_ff + `SRE_ADDR_STEP;
                        end else begin
                            nxt_cnt = cnt_ff + `SRE_BIT_STEP;
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_oe = ~sh_ff[6];
                        end
                    end
                end
                S_RACK: begin
                    // Master ack is sampled on the ninth rising edge
                    if (scl_rise) begin
                        if (sda_s2_ff == `SRE_LINE_LOW) begin
                            nxt_st = S_ACKD;
                            nxt_cont = N_RD;
                        end else begin
                            nxt_st = S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    nxt_oe = 1'b0;
                end
                S_IDLE: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    nxt_st = S_IDLE;
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= S_IDLE;
            cont_ff <= N_RD;
            cnt_ff <= `SRE_BIT_FIRST;
            sh_ff <= 8'h00;
            addr_ff <= {ADDR_W{1'b0}};
            oe_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cont_ff <= nxt_cont;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            addr_ff <= nxt_addr;
            oe_ff <= nxt_oe;
        end
    end

    // ============================================================
    // Memory load path
    // The buffer drains only while the bus is idle, so a long session fills it
    assign fifo_data = {load_addr, load_data};
    assign drain_ready = (st_ff == S_IDLE);

    sre_fifo #(
        .W(MEM_AW + 8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_load_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(load_valid),
        .in_ready(load_ready),
        .in_data(fifo_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // Array write from the buffer; never during a bus session
    always @(posedge clk) begin
        if (drain_valid & drain_ready) begin
            mem_ff[drain_data[MEM_AW+7:8]] <= drain_data[7:0];
        end
    end

    // ============================================================
    // Outputs
    // Open drain: only ever drive low, the enable carries the data
    assign sda_out = `SRE_LINE_LOW;
    assign sda_oe = oe_ff;
    assign sess_busy = (st_ff != S_IDLE);
    assign cur_addr = addr_ff;
endmodule // sre_read_engine

`default_nettype wire
